// File: verilog/servo_mode_ctl.sv
// Mode select, start qualification, reboot and alarm contact logic.
// Assumes servo on, motion and command validity come from the drive core,
// and that the core honours the start, jog, decel and discard strobes.
//
// Operation
// (RULE1) All selects high: automatic mode, positioning starts on accepted go.
// (RULE2) Only hand select low: manual mode, constant speed jog on cw/ccw.
// (RULE3) Only train select low: pulse mode, follow pulse-train commands.
// (RULE4) Only home select low: home-return mode, start homing on accepted go.
// (RULE5) Two or more selects low: mode error, fault output, motion inhibited.
// (RULE6) Mode change while moving: decelerate to stop at the set rate.
// (RULE7) Interrupted move: discard remaining command data, no resume.
// (RULE8) Host waits 50 ms after a mode change before go or jog.
// (RULE9) Auto lamp low only with servo on and automatic mode.
// (RULE10) Hand lamp low only with servo on and manual mode.
// (RULE11) Option bits B and C select the go input polarity, four ways.
// (RULE12) Host holds go active at least 8 ms.
// (RULE13) Go starts motion only with servo on, right mode, stop ok, valid commands.
// (RULE14) Go with invalid position or speed raises the command fault instead.
// (RULE15) Go ignored with servo off, motor moving or wrong mode.
// (RULE16) Reboot input or serial reboot restarts as a power cycle, reloading options.
// (RULE17) After reboot alarm output off about 2 s, then on and run.
// (RULE18) Fault clear input or serial clear clears a pending alarm; so does reboot.
// (RULE19) Host holds reboot or fault clear low at least 8 ms.
// (RULE20) Alarm output low in normal running, high once an alarm is seen.
// (RULE21) Outside circuit should drop main power when alarm output goes off.
// (RULE22) Four fault code pins tell the kind of alarm or error.
// (RULE23) Mode error clears on servo off or a legal select combination.
// (RULE24) Contacts are synchronised and filtered to the minimum width.
// (RULE25) Mode decode and lamps follow the inputs continuously.

`include "servo_mode_defines.svh"

module servo_mode_ctl
	import servo_mode_pkg::*;
#(
	parameter int CONTACT_CYCLES = `CONTACT_MIN_CYC,
	parameter int BOOT_CYCLES    = `BOOT_HOLD_CYC
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        homeReturnModeSelN,
	input  wire logic        handJogModeSelN,
	input  wire logic        trainFollowModeSelN,
	input  wire logic        motionGoIn,
	input  wire logic        jogCcwInN,
	input  wire logic        jogCwInN,
	input  wire logic        stopInN,
	input  wire logic        driveRebootInN,
	input  wire logic        faultClearInN,
	input  wire logic        serialRebootCmd,
	input  wire logic        serialFaultClearCmd,
	input  wire logic [15:0] optionSwitchWord,
	input  wire logic        servoOnIn,
	input  wire logic        motorMoving,
	input  wire logic        posCmdValid,
	input  wire logic        speedCmdValid,
	input  wire logic        alarmDetect,
	input  wire logic [3:0]  alarmType,
	output      logic        autoModeLampN,
	output      logic        handModeLampN,
	output      logic        commandFaultOutN,
	output      logic        alarmOutN,
	output      logic        faultCodeBit0N,
	output      logic        faultCodeBit1N,
	output      logic        faultCodeBit2N,
	output      logic        faultCodeBit3N,
	output      logic        startAutoMove,
	output      logic        startHomeReturn,
	output      logic        decelStop,
	output      logic        discardCmd,
	output      logic        jogCwRun,
	output      logic        jogCcwRun,
	output      logic        pulseFollowEn,
	output      logic        motionInhibit,
	output      logic        driveRestart,
	output      mode_type    selectedMode
);

	ctl_state_type st_r;
	ctl_state_type st_nxt;
	contact_type   c;
	mode_type      modeNow;
	logic          running;
	logic          servoAct;
	logic          rebootEv;
	logic          clearEv;
	logic          goEv;
	logic          stopOk;

	// ----------------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------------
	if (BOOT_CYCLES < 2)
	begin : g_bad
		$error("servo_mode_ctl: BOOT_CYCLES must be at least 2");
	end

	// ----------------------------------------------------------------------
	// Contact inputs
	// ----------------------------------------------------------------------
	// One filter instance for all contacts keeps their delays equal, so
	// a mode change and a go pressed together are seen in the same order.
	contact_filter #(
		.WIDTH       ($bits(contact_type)),
		.MIN_CYCLES  (CONTACT_CYCLES),
		.RESET_LEVEL ('1)
	) u_filter (
		.clk       (clk),
		.srst      (srst),
		.rawIn     ({homeReturnModeSelN, handJogModeSelN, trainFollowModeSelN, motionGoIn,
		             jogCcwInN, jogCwInN, stopInN, driveRebootInN, faultClearInN}),
		.stableOut (c)
	);

	// ----------------------------------------------------------------------
	// Decode and events
	// ----------------------------------------------------------------------
	// Decode runs every cycle regardless of go. [RULE25]
	always_comb
	begin
		unique case ({c.homeN, c.handN, c.trainN})
			3'b111:  modeNow = MODE_AUTO;   // [RULE1]
			3'b101:  modeNow = MODE_MANUAL; // [RULE2]
			3'b110:  modeNow = MODE_PULSE;  // [RULE3]
			3'b011:  modeNow = MODE_HOME;   // [RULE4]
			default: modeNow = MODE_ILLEGAL;
		endcase
	end

	// Servo is only on once the boot hold is over and no alarm stands.
	assign running  = (st_r.boot == BOOT_RUN);
	assign servoAct = running && servoOnIn && !st_r.alarm;
	assign rebootEv = running && ((st_r.prev.rebootN && !c.rebootN) || serialRebootCmd);
	assign clearEv  = (st_r.prev.clearN && !c.clearN) || serialFaultClearCmd;
	assign stopOk   = !c.stopN || st_r.opt[`OPT_STOP_DIS];

	// Go trigger: 00 closing edge, 01 opening edge, 10 either edge,
	// 11 high level. Options are zeroed by reset or reboot and loaded at boot end. [RULE11]
	always_comb
	begin
		unique case ({st_r.opt[`OPT_GO_POL_C], st_r.opt[`OPT_GO_POL_B]})
			2'b00: goEv = st_r.prev.goPin && !c.goPin;
			2'b01: goEv = !st_r.prev.goPin && c.goPin;
			2'b10: goEv = st_r.prev.goPin != c.goPin;
			2'b11: goEv = c.goPin;
		endcase
	end

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb
	begin
		st_nxt           = st_r;
		st_nxt.prev      = c;
		st_nxt.startAuto = 1'b0;
		st_nxt.startHome = 1'b0;
		st_nxt.decel     = 1'b0;
		st_nxt.discard   = 1'b0;
		if (!running)
		begin
			// Hold everything quiet for the boot time, then load options.
			st_nxt.bootCnt = st_r.bootCnt + 32'h1;
			if (st_r.bootCnt >= 32'(BOOT_CYCLES - 1))
			begin
				st_nxt.boot    = BOOT_RUN; // [RULE17]
				st_nxt.bootCnt = 32'h0;
				st_nxt.opt     = optionSwitchWord; // [RULE16]
			end
			st_nxt.mode    = modeNow;
			st_nxt.alarmOn = 1'b0; // [RULE17]
		end
		else
		begin
			st_nxt.mode = modeNow;
			// A select change under motion stops and flushes the move.
			if (modeNow != st_r.mode && motorMoving)
			begin
				st_nxt.decel   = 1'b1; // [RULE6]
				st_nxt.discard = 1'b1; // [RULE7]
			end
			// Mode error only while servo on; it drops on its own. [RULE23]
			st_nxt.modeErr = servoAct && modeNow == MODE_ILLEGAL; // [RULE5]
			// Leaving the go modes clears a pending command error.
			if (modeNow != MODE_AUTO && modeNow != MODE_HOME)
			begin
				st_nxt.posErr = 1'b0;
				st_nxt.spdErr = 1'b0;
			end
			// Start qualification; anything short of it ignores go. [RULE15]
			if (goEv && servoAct && !motorMoving && stopOk
			    && (modeNow == MODE_AUTO || modeNow == MODE_HOME))
			begin
				if (posCmdValid && speedCmdValid)
				begin
					st_nxt.startAuto = modeNow == MODE_AUTO; // [RULE13] [RULE1]
					st_nxt.startHome = modeNow == MODE_HOME; // [RULE13] [RULE4]
					st_nxt.posErr    = 1'b0;
					st_nxt.spdErr    = 1'b0;
				end
				else
				begin
					st_nxt.posErr = !posCmdValid;   // [RULE14]
					st_nxt.spdErr = !speedCmdValid; // [RULE14]
				end
			end
			// Jog runs only with one direction held and a valid speed.
			st_nxt.jogCw  = servoAct && modeNow == MODE_MANUAL && !c.jogCwN
			                && c.jogCcwN && speedCmdValid; // [RULE2]
			st_nxt.jogCcw = servoAct && modeNow == MODE_MANUAL && !c.jogCcwN
			                && c.jogCwN && speedCmdValid; // [RULE2]
			st_nxt.pulseEn  = servoAct && modeNow == MODE_PULSE; // [RULE3]
			st_nxt.motionEn = servoAct && modeNow != MODE_ILLEGAL; // [RULE5]
			st_nxt.autoLamp = servoAct && modeNow == MODE_AUTO; // [RULE9]
			st_nxt.handLamp = servoAct && modeNow == MODE_MANUAL; // [RULE10]
			// Clear first, detect second, so a clear in the same cycle never hides a new alarm.
			if (clearEv)
				st_nxt.alarm = 1'b0; // [RULE18]
			if (alarmDetect)
			begin
				st_nxt.alarm     = 1'b1; // [RULE20]
				st_nxt.alarmCode = alarmType;
			end
			st_nxt.alarmOn = !st_nxt.alarm; // [RULE20]
		end
		// Fault code pins, alarm first, then mode, position, speed. [RULE22]
		if (st_nxt.alarm)
			st_nxt.codeInv = ~st_nxt.alarmCode;
		else if (st_nxt.modeErr)
			st_nxt.codeInv = ~`CODE_MODE;
		else if (st_nxt.posErr)
			st_nxt.codeInv = ~`CODE_POS;
		else if (st_nxt.spdErr)
			st_nxt.codeInv = ~`CODE_SPEED;
		else
			st_nxt.codeInv = ~`CODE_NORMAL;
		// Reboot behaves as a power cycle: back to the all-zero state. [RULE16]
		if (rebootEv)
		begin
			st_nxt      = '0; // [RULE18]
			st_nxt.prev = c;
		end
	end

	// All-zero reset is the boot hold, outputs inactive except motionInhibit and driveRestart.
	always_ff @(posedge clk)
	begin
		if (srst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	// Pins are active low; flags are stored active high so reset is zero.
	assign autoModeLampN    = !st_r.autoLamp;
	assign handModeLampN    = !st_r.handLamp;
	assign commandFaultOutN = !(st_r.modeErr || st_r.posErr || st_r.spdErr);
	assign alarmOutN        = !st_r.alarmOn;
	assign faultCodeBit0N   = !st_r.codeInv[0];
	assign faultCodeBit1N   = !st_r.codeInv[1];
	assign faultCodeBit2N   = !st_r.codeInv[2];
	assign faultCodeBit3N   = !st_r.codeInv[3];
	assign startAutoMove    = st_r.startAuto;
	assign startHomeReturn  = st_r.startHome;
	assign decelStop        = st_r.decel;
	assign discardCmd       = st_r.discard;
	assign jogCwRun         = st_r.jogCw;
	assign jogCcwRun        = st_r.jogCcw;
	assign pulseFollowEn    = st_r.pulseEn;
	assign motionInhibit    = !st_r.motionEn;
	assign driveRestart     = !running;
	assign selectedMode     = st_r.mode;

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence rebootSeen;
		rebootEv;
	endsequence

	sequence bootHeld;
		(alarmOutN && driveRestart) [*8];
	endsequence

	chk_auto_lamp_on: assert property (servoAct && modeNow == MODE_AUTO && !rebootEv |=> !autoModeLampN) // [RULE9]
		else $error("auto lamp not lit in automatic mode");
	chk_hand_lamp_on: assert property (servoAct && modeNow == MODE_MANUAL && !rebootEv |=> !handModeLampN) // [RULE10]
		else $error("hand lamp not lit in manual mode");
	chk_lamps_servo_off: assert property (!servoOnIn |=> autoModeLampN && handModeLampN) // [RULE9]
		else $error("lamp lit with servo off");
	chk_pulse_follow: assert property (servoAct && modeNow == MODE_PULSE && !rebootEv |=> pulseFollowEn) // [RULE3]
		else $error("pulse follow not enabled in pulse mode");
	chk_mode_error_out: assert property (servoAct && modeNow == MODE_ILLEGAL && !rebootEv
		|=> !commandFaultOutN && motionInhibit && faultCodeBit0N == 1'b1) // [RULE5]
		else $error("mode error not flagged");
	chk_decel_on_change: assert property (running && motorMoving && modeNow != st_r.mode && !rebootEv
		|=> decelStop && discardCmd) // [RULE6]
		else $error("no stop on mode change under motion");
	chk_go_ignored: assert property (goEv && (motorMoving || !servoOnIn)
		|=> !startAutoMove && !startHomeReturn) // [RULE15]
		else $error("go accepted while it must be ignored");
	chk_home_start: assert property (goEv && servoAct && stopOk && !motorMoving && modeNow == MODE_HOME
		&& posCmdValid && speedCmdValid && !rebootEv |=> startHomeReturn ##1 !startHomeReturn) // [RULE4]
		else $error("home return not started");
	chk_cmd_fault_go: assert property (goEv && servoAct && stopOk && !motorMoving && modeNow == MODE_AUTO
		&& !posCmdValid && !rebootEv |=> !commandFaultOutN && !startAutoMove) // [RULE14]
		else $error("invalid position did not raise fault");
	chk_boot_hold: assert property (rebootSeen |=> bootHeld) // [RULE17]
		else $error("alarm output not held off after reboot");
	chk_alarm_off: assert property (running && alarmDetect && !rebootEv |=> alarmOutN && !servoAct) // [RULE20]
		else $error("alarm output stayed on after alarm");
	chk_alarm_clear: assert property (running && st_r.alarm && clearEv && !alarmDetect && !rebootEv
		|=> !alarmOutN) // [RULE18]
		else $error("alarm not cleared");

	// ----------------------------------------------------------------------
	// Further checks on jog, flush, code pins and mode error recovery
	// ----------------------------------------------------------------------
	// A jog runs in manual mode only and never in both directions at once.
	sequence jogActive;
		jogCwRun || jogCcwRun;
	endsequence

	chk_jog_one_way: assert property (!(jogCwRun && jogCcwRun)) // [RULE2]
		else $error("jog running both ways");
	chk_jog_mode: assert property (jogActive |-> selectedMode == MODE_MANUAL) // [RULE2]
		else $error("jog running outside manual mode");

	// A flush never comes without its stop, so no stale move can resume.
	chk_discard_decel: assert property (discardCmd |-> decelStop) // [RULE7]
		else $error("command flush without stop");

	// With no fault and no alarm the code pins rest at the normal code.
	chk_normal_code: assert property (commandFaultOutN && !alarmOutN
		|-> {faultCodeBit3N, faultCodeBit2N, faultCodeBit1N, faultCodeBit0N} == `CODE_NORMAL) // [RULE22]
		else $error("fault code shown with no fault");

	// The mode error drops by itself once the selects are legal again.
	chk_mode_err_clear: assert property (running && modeNow != MODE_ILLEGAL && !rebootEv
		|=> !st_r.modeErr) // [RULE23]
		else $error("mode error stayed after legal selects");

endmodule // servo_mode_ctl

// File: verilog/servo_mode_defines.svh
// Constants of the mode select and start logic: timing, option bits, codes.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef SERVO_MODE_DEFINES_SVH
`define SERVO_MODE_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   8
`define CONTACT_MIN_NS  8000000
`define CONTACT_MIN_CYC ((`CONTACT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOT_HOLD_MS    2000
`define BOOT_HOLD_CYC   (`BOOT_HOLD_MS * (1000000 / `CLK_PERIOD_NS))

// ----------------------------------------------------------------------
// Option word bits and reset value
// ----------------------------------------------------------------------
`define OPT_GO_POL_B    11
`define OPT_GO_POL_C    12
`define OPT_STOP_DIS    13
`define OPT_RESET       16'h0000

// ----------------------------------------------------------------------
// Fault code pin levels, bit 3 down to bit 0
// ----------------------------------------------------------------------
`define CODE_NORMAL     4'hF
`define CODE_MODE       4'h5
`define CODE_POS        4'h4
`define CODE_SPEED      4'h3

`endif

// File: verilog/servo_mode_pkg.sv
// Types shared by the mode select and start logic.
// Assumes the defines header is compiled alongside.
package servo_mode_pkg;

	// ----------------------------------------------------------------------
	// Modes and boot phases
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {MODE_AUTO, MODE_MANUAL, MODE_PULSE, MODE_HOME, MODE_ILLEGAL} mode_type;
	typedef enum logic {BOOT_HOLD, BOOT_RUN} boot_type;

	// ----------------------------------------------------------------------
	// Filtered contact levels, pin polarity kept
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic homeN;
		logic handN;
		logic trainN;
		logic goPin;
		logic jogCcwN;
		logic jogCwN;
		logic stopN;
		logic rebootN;
		logic clearN;
	} contact_type;

	// ----------------------------------------------------------------------
	// Control state; all zero is the reset state
	// ----------------------------------------------------------------------
	typedef struct packed {
		boot_type    boot;
		logic [31:0] bootCnt;
		logic [15:0] opt;
		mode_type    mode;
		contact_type prev;
		logic        modeErr;
		logic        posErr;
		logic        spdErr;
		logic        alarm;
		logic [3:0]  alarmCode;
		logic        alarmOn;
		logic        autoLamp;
		logic        handLamp;
		logic [3:0]  codeInv;
		logic        startAuto;
		logic        startHome;
		logic        decel;
		logic        discard;
		logic        jogCw;
		logic        jogCcw;
		logic        pulseEn;
		logic        motionEn;
	} ctl_state_type;

endpackage

// File: verilog/contact_filter.sv
// Synchroniser and minimum-width filter for a group of contact inputs.
// Assumes inputs may change at any time; output moves only after a
// level has been steady for MIN_CYCLES clocks.
`include "servo_mode_defines.svh"

module contact_filter #(
	parameter int                 WIDTH       = 9,
	parameter int                 MIN_CYCLES  = `CONTACT_MIN_CYC,
	parameter logic [WIDTH-1:0]   RESET_LEVEL = '1
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] rawIn,
	output      logic [WIDTH-1:0] stableOut
);

	localparam int CW = $clog2(MIN_CYCLES);

	typedef struct packed {
		logic [WIDTH-1:0]         s1;
		logic [WIDTH-1:0]         s2;
		logic [WIDTH-1:0]         level;
		logic [WIDTH-1:0][CW-1:0] cnt;
	} filt_state_type;

	filt_state_type st_r;
	filt_state_type st_nxt;

	// ----------------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------------
	if (MIN_CYCLES < 2 || WIDTH < 1)
	begin : g_bad
		$error("contact_filter: MIN_CYCLES must be at least 2");
	end

	// ----------------------------------------------------------------------
	// Filter
	// ----------------------------------------------------------------------
	// Only the second stage looks at the first, so metastability stays
	// inside the synchroniser. A glitch shorter than the window is lost.
	always_comb
	begin
		st_nxt    = st_r;
		st_nxt.s1 = rawIn;
		st_nxt.s2 = st_r.s1;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st_r.s2[i] == st_r.level[i])
				st_nxt.cnt[i] = '0;
			else if (st_r.cnt[i] == CW'(MIN_CYCLES - 1))
			begin
				st_nxt.level[i] = st_r.s2[i]; // [RULE24] [RULE12] [RULE19]
				st_nxt.cnt[i]   = '0;
			end
			else
				st_nxt.cnt[i] = st_r.cnt[i] + CW'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st_r <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, level: RESET_LEVEL, cnt: '0};
		else
			st_r <= st_nxt;
	end

	assign stableOut = st_r.level;

endmodule // contact_filter

// File: dv/host_contact_model.sv
// Host controller model: drives the nine contact inputs of the mode logic.
// Assumes one free-running clock; contacts change only on its falling edge.
module host_contact_model #(
	parameter int HOLD   = 8,
	parameter int SETTLE = 12
) (
	input  wire logic clk,
	input  wire logic alarmOutN,
	output      logic [8:0] pins,
	output      logic mainPowerEn
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------------
	// Contacts: home, hand, train, go, ccw, cw, stop, reboot, clear
	// ----------------------------------------------------------------------
	// Idle: every contact open except stop, which is closed so starts may pass.
	initial pins = 9'h1FB;

	// Main power drops whenever the alarm output opens.
	assign mainPowerEn = ~alarmOutN;

	// Mode selects change, then no go or jog for the settle span.
	task automatic setMode(input logic [2:0] selN);
		@(negedge clk);
		pins[8:6] = selN;
		repeat (SETTLE) @(negedge clk);
	endtask

	// A level change on one contact.
	task automatic setPin(input int idx, input logic val);
		@(negedge clk);
		pins[idx] = val;
	endtask

	// A contact is toggled for len cycles; callers use HOLD unless testing the filter.
	task automatic press(input int idx, input int len);
		@(negedge clk);
		pins[idx] = ~pins[idx];
		repeat (len) @(negedge clk);
		pins[idx] = ~pins[idx];
	endtask
endmodule // host_contact_model

// File: dv/servo_mode_select_and_start_logic_tb.sv
// Self-checking bench of the mode select and start logic.
// Assumes the defines header and package are compiled first; short counts.
`include "servo_mode_defines.svh"
module servo_mode_select_and_start_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import servo_mode_pkg::*;

	logic clk, srst, sRb, sClr, servoOn, moving, posV, spdV, alDet, aN, hN, fN, alN, sam, shr, dec, dis;
	logic cwR, ccwR, pEn, inh, rst, pwr;
	logic [15:0] opt;
	logic [3:0] alType, codeN;
	logic [8:0] pins;
	mode_type selMode, m;
	int mismatches, comparisons, nAuto, nHome, nDec, nBoth, a, b, n;

	host_contact_model host_u (.clk(clk), .alarmOutN(alN), .pins(pins), .mainPowerEn(pwr));

	servo_mode_ctl #(.CONTACT_CYCLES(4), .BOOT_CYCLES(20)) dut_u (
		.clk(clk), .srst(srst), .homeReturnModeSelN(pins[8]), .handJogModeSelN(pins[7]),
		.trainFollowModeSelN(pins[6]), .motionGoIn(pins[5]), .jogCcwInN(pins[4]), .jogCwInN(pins[3]),
		.stopInN(pins[2]), .driveRebootInN(pins[1]), .faultClearInN(pins[0]), .serialRebootCmd(sRb),
		.serialFaultClearCmd(sClr), .optionSwitchWord(opt), .servoOnIn(servoOn), .motorMoving(moving),
		.posCmdValid(posV), .speedCmdValid(spdV), .alarmDetect(alDet), .alarmType(alType),
		.autoModeLampN(aN), .handModeLampN(hN), .commandFaultOutN(fN), .alarmOutN(alN),
		.faultCodeBit0N(codeN[0]), .faultCodeBit1N(codeN[1]), .faultCodeBit2N(codeN[2]),
		.faultCodeBit3N(codeN[3]), .startAutoMove(sam), .startHomeReturn(shr), .decelStop(dec),
		.discardCmd(dis), .jogCwRun(cwR), .jogCcwRun(ccwR), .pulseFollowEn(pEn), .motionInhibit(inh),
		.driveRestart(rst), .selectedMode(selMode));

	// ----------------------------------------------------------------------
	// Clock, pulse counters and helpers
	// ----------------------------------------------------------------------
	initial
	begin
		clk = 0;
		forever #4 clk = ~clk;
	end

	// One-cycle strobes are counted on every rising edge so none slips between checks.
	always @(posedge clk)
	begin
		if (sam === 1'b1) nAuto++;
		if (shr === 1'b1) nHome++;
		if (dec === 1'b1) nDec++;
		if (dec === 1'b1 && dis === 1'b1) nBoth++;
	end

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s seen %0h exp %0h", $time, msg, seen, exp);
		end
	endtask

	// Select pins {home, hand, train} to the mode they pick.
	function automatic mode_type expMode(input logic [2:0] s);
		case (s)
			3'h7: return MODE_AUTO;
			3'h5: return MODE_MANUAL;
			3'h6: return MODE_PULSE;
			3'h3: return MODE_HOME;
			default: return MODE_ILLEGAL;
		endcase
	endfunction

	// Serial reboot pulse, then wait out the boot hold.
	task automatic reboot();
		@(negedge clk);
		sRb = 1;
		@(negedge clk);
		sRb = 0;
		check(rst, 1, "restart");
		cyc(40);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Long enough for every scenario with a wide margin.
	initial
	begin
		#(8 * 30000);
		mismatches++;
		print_verdict();
	end

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	initial
	begin
		{srst, sRb, sClr, servoOn, moving, posV, spdV, alDet} = 8'h86;
		{opt, alType} = 20'h00000;
		void'($urandom(10));
		cyc(20);
		srst = 0;
		check({alN, rst}, 2'h3, "boot start");
		n = 0;
		while (rst !== 1'b0 && n < 100)
		begin
			cyc(1);
			n++;
		end
		check(n >= 18 && n <= 22, 1, "boot length");
		cyc(12);
		check(alN, 0, "alarm on");
		// Every select combination, then random ones with servo on and off.
		for (int i = 0; i < 16; i++)
		begin
			servoOn = (i < 8) ? 1'b1 : 1'($urandom);
			{moving, spdV} = (i < 8) ? 2'h1 : 2'($urandom);
			host_u.setMode((i < 8) ? 3'(i) : 3'($urandom));
			m = expMode(pins[8:6]);
			if (servoOn) check(selMode, m, "mode");
			check(aN, !(servoOn && m == MODE_AUTO), "auto lamp");
			check(hN, !(servoOn && m == MODE_MANUAL), "hand lamp");
			check(fN, !(servoOn && m == MODE_ILLEGAL), "mode fault");
			check(pEn, servoOn && m == MODE_PULSE, "pulse follow");
			if (servoOn && m == MODE_ILLEGAL) check({inh, codeN}, {1'b1, `CODE_MODE}, "inhibit");
		end
		{servoOn, moving, spdV} = 3'h5;
		host_u.setMode(3'h7);
		// All four go polarities, each loaded by a reboot.
		for (int p = 3; p >= 0; p--)
		begin
			opt = 16'h0000;
			opt[12:11] = 2'(p);
			reboot();
			nAuto = 0;
			host_u.setPin(5, 0);
			cyc(30);
			a = nAuto;
			nAuto = 0;
			host_u.setPin(5, 1);
			cyc(30);
			b = nAuto;
			if (p == 3) check(b != 0, 1, "level go");
			else check({a[15:0], b[15:0]}, {16'(p != 1), 16'(p != 0)}, "edge go");
		end
		host_u.setMode(3'h3);
		nHome = 0;
		host_u.press(5, 8);
		cyc(20);
		check(nHome, 1, "home start");
		// Go refused: servo off, moving, manual, stop open, too short.
		for (int k = 0; k < 5; k++)
		begin
			servoOn = (k != 0);
			moving = (k == 1);
			host_u.setPin(2, k == 3);
			host_u.setMode(k == 2 ? 3'h5 : 3'h7);
			nAuto = 0;
			host_u.press(5, k == 4 ? 2 : 8);
			cyc(20);
			check(nAuto, 0, "go refused");
		end
		{servoOn, moving} = 2'h2;
		host_u.setPin(2, 0);
		cyc(12);
		// Position fault, speed fault, then a clean start.
		for (int k = 0; k < 3; k++)
		begin
			posV = (k != 0);
			spdV = (k != 1);
			nAuto = 0;
			host_u.press(5, 8);
			cyc(20);
			check(fN, k == 2, "cmd fault");
			check(nAuto, k == 2, "start");
			if (k < 2) check(codeN, k == 0 ? `CODE_POS : `CODE_SPEED, "cmd code");
		end
		// Mode change while moving.
		moving = 1;
		{nDec, nBoth} = 64'h0;
		host_u.setMode(3'h3);
		check({nDec[15:0], nBoth[15:0]}, {16'h1, 16'h1}, "decel discard");
		moving = 0;
		host_u.setMode(3'h5);
		host_u.setPin(3, 0);
		cyc(12);
		check({cwR, ccwR}, 2'h2, "jog cw");
		host_u.setPin(3, 1);
		host_u.setPin(4, 0);
		cyc(12);
		check({cwR, ccwR}, 2'h1, "jog ccw");
		host_u.setPin(4, 1);
		host_u.setMode(3'h7);
		// Alarms: cleared by contact, by serial command, then by reboot contact.
		for (int k = 0; k < 3; k++)
		begin
			alType = 4'($urandom);
			alDet = 1;
			cyc(1);
			alDet = 0;
			cyc(2);
			check({alN, codeN, pwr}, {1'b1, alType, 1'b0}, "alarm");
			check(aN, 1, "lamp off");
			if (k == 1) {sClr, alDet} = 2'h2;
			cyc(1);
			sClr = 0;
			if (k != 1) host_u.press(k == 0 ? 0 : 1, 8);
			if (k == 2) check(rst, 1, "reboot pin");
			cyc(40);
			check({alN, codeN, pwr}, {1'b0, `CODE_NORMAL, 1'b1}, "alarm clear");
		end
		print_verdict();
	end
endmodule // servo_mode_select_and_start_logic_tb
